// ### logic/ptp_evt_top.sv
// Time-triggered outputs and input timestamp capture on seven pins
`timescale 1ns/1ps
module ptp_evt_top
    import ptp_evt_pkg::*;
#(
    parameter int UNITS = NUM_UNITS,
    parameter int PINS  = NUM_PINS
)
(
    input  wire logic                    clk_sys_i,
    input  wire logic                    rstn_i,
    input  wire logic                    ce_i,
    input  wire logic                    time_load_i,
    input  wire ptp_time_type            time_load_val_i,
    output ptp_time_type                 sys_time_o,
    input  wire trig_cfg_type [UNITS-1:0] trig_cfg_i,
    input  wire logic [UNITS-1:0]        trigger_unit_enable_reg_i,
    input  wire logic [2*UNITS-1:0]      trigger_irq_enable_reg_i,
    input  wire logic [2*UNITS-1:0]      trigger_irq_clear_i,
    output logic [2*UNITS-1:0]           trigger_irq_status_reg_o,
    output logic [UNITS-1:0]             trigger_active_o,
    input  wire logic [UNITS-1:0][15:0]  capture_unit_config_i,
    input  wire logic [UNITS-1:0]        capture_unit_enable_reg_i,
    input  wire logic [UNITS-1:0]        capture_ready_clear_i,
    output logic [UNITS-1:0]             capture_ready_reg_o,
    input  wire logic [UNITS-1:0]        capture_irq_enable_reg_i,
    output logic [UNITS-1:0]             capture_irq_status_reg_o,
    output cap_sample_type [UNITS-1:0][DEPTH_LAST-1:0] capture_sample_o,
    output logic [UNITS-1:0][3:0]        capture_edge_count_o,
    output logic [UNITS-1:0]             capture_overflow_o,
    input  wire logic [15:0]             main_irq_enable_reg_i,
    output logic [15:0]                  main_irq_status_reg_o,
    output logic                         shared_irq_pin_n_o,
    input  wire logic [PINS-1:0]         gpio_in_i,
    output logic [PINS-1:0]              gpio_out_o,
    output logic [PINS-1:0]              gpio_oe_n_o
);
    logic [1:0]        div_r;
    logic              tick;
    logic [2:0]        phase_r;
    ptp_time_type      time_r;
    logic [PINS-1:0]   s1_r;
    logic [PINS-1:0]   s2_r;
    logic [PINS-1:0]   s3_r;
    logic [PINS-1:0]   level_r;
    logic [PINS-1:0]   rise;
    logic [PINS-1:0]   fall;
    logic [UNITS-1:0]  tout;
    logic [UNITS-1:0]  tact;
    logic [UNITS-1:0]  tdone;
    logic [UNITS-1:0]  terr;
    logic [UNITS-1:0]  chain_go;
    logic [PINS-1:0]   pin_val;
    logic [PINS-1:0]   pin_used;

    // System time: one step per 25 MHz tick, phase per 10 ns clock cycle
    assign tick = (div_r == 2'(TICK_DIV - 1));

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            div_r   <= 2'h0;
            phase_r <= 3'h0;
            time_r  <= '0;
        end
        else if (ce_i)
        begin
            div_r   <= tick ? 2'h0 : div_r + 2'h1;
            phase_r <= tick ? 3'h0 : ((phase_r == 3'h4) ? 3'h4 : phase_r + 3'h1);
            if (time_load_i)
                time_r <= time_load_val_i;
            else if (tick)
            begin
                if (time_r.ns >= 30'(NS_PER_SEC - TICK_NS))
                begin
                    time_r.ns  <= 30'h0;
                    time_r.sec <= time_r.sec + 32'h1;
                end
                else
                    time_r.ns <= time_r.ns + 30'(TICK_NS);
            end
        end
    end
    assign sys_time_o = time_r;

    // Pin input synchronisers
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s1_r    <= '0;
            s2_r    <= '0;
            s3_r    <= '0;
            level_r <= '0;
        end
        else if (ce_i)
        begin
            s1_r <= gpio_in_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int p = 0; p < PINS; p++)
                if (s2_r[p] == s3_r[p])
                    level_r[p] <= s3_r[p];
        end
    end
    assign rise = ~level_r & s2_r & s3_r;
    assign fall = level_r & ~s2_r & ~s3_r;

    // Trigger units and chain hand-off
    for (genvar u = 0; u < UNITS; u++)
    begin : g_trig
        always_comb
        begin
            chain_go[u] = 1'b0;
            for (int v = 0; v < UNITS; v++)
                if (trig_cfg_i[v].chain_en && trig_cfg_i[v].chain_next == 4'(u) && tdone[v])
                    chain_go[u] = 1'b1;
        end

        trig_unit u_trig (
            .clk_sys_i     (clk_sys_i),
            .rstn_i        (rstn_i),
            .ce_i          (ce_i),
            .tick_i        (tick),
            .now_i         (time_r),
            .cfg_i         (trig_cfg_i[u]),
            .enable_i      (trigger_unit_enable_reg_i[u]),
            .chain_start_i (chain_go[u]),
            .out_o         (tout[u]),
            .active_o      (tact[u]),
            .done_o        (tdone[u]),
            .error_o       (terr[u])
        );
    end
    assign trigger_active_o = tact;

    // Pin drive: OR of every enabled unit routed to a pin
    always_comb
    begin
        pin_val  = '0;
        pin_used = '0;
        for (int p = 0; p < PINS; p++)
            for (int u = 0; u < UNITS; u++)
                if (trigger_unit_enable_reg_i[u] &&
                    trig_cfg_i[u].config_first[PIN_SEL_LSB +: PIN_SEL_W] == 4'(p))
                begin
                    pin_val[p]  = pin_val[p] | tout[u];
                    pin_used[p] = 1'b1;
                end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            gpio_out_o  <= '0;
            gpio_oe_n_o <= '1;
        end
        else if (ce_i)
        begin
            gpio_out_o  <= pin_val;
            gpio_oe_n_o <= ~pin_used;
        end
    end

    // Trigger interrupt status: done bits low half, error bits high half
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            trigger_irq_status_reg_o <= '0;
        else if (ce_i)
            trigger_irq_status_reg_o <= (trigger_irq_status_reg_o & ~trigger_irq_clear_i)
                                        | {terr, tdone};
    end

    // Capture units
    for (genvar u = 0; u < UNITS; u++)
    begin : g_cap
        localparam int DEPTH = (u == UNITS - 1) ? DEPTH_LAST : DEPTH_SMALL;
        logic [3:0]  src;
        logic [1:0]  det;
        logic        r_ev;
        logic        f_ev;
        logic        ev;
        logic        last_of;
        logic [3:0]  cnt_r;
        logic [3:0]  wr_r;
        logic        edge_pol;

        assign src = capture_unit_config_i[u][CAP_PIN_LSB +: PIN_SEL_W];
        assign det = capture_unit_config_i[u][CAP_DET_LSB +: 2];
        assign r_ev = (src < 4'(PINS)) && rise[src[2:0]];
        assign f_ev = (src < 4'(PINS)) && fall[src[2:0]];
        always_comb
        begin
            unique case (det)
                DET_RISE:      ev = r_ev;
                DET_FALL:      ev = f_ev;
                DET_POS_PULSE: ev = r_ev | f_ev;
                DET_NEG_PULSE: ev = r_ev | f_ev;
            endcase
        end
        assign edge_pol = r_ev;
        assign last_of  = (wr_r == 4'(DEPTH));

        always_ff @(posedge clk_sys_i or negedge rstn_i)
        begin
            if (!rstn_i)
            begin
                cnt_r                   <= 4'h0;
                wr_r                    <= 4'h0;
                capture_overflow_o[u]   <= 1'b0;
                capture_ready_reg_o[u]  <= 1'b0;
                capture_sample_o[u]     <= '0;
            end
            else if (ce_i)
            begin
                if (capture_ready_clear_i[u])
                begin
                    capture_ready_reg_o[u] <= 1'b0;
                    wr_r                   <= 4'h0;
                    cnt_r                  <= 4'h0;
                    capture_overflow_o[u]  <= 1'b0;
                end
                if (capture_unit_enable_reg_i[u] && ev)
                begin
                    cnt_r <= capture_ready_clear_i[u] ? 4'h1 : cnt_r + 4'h1;
                    if (last_of && !capture_ready_clear_i[u])
                        capture_overflow_o[u] <= 1'b1;
                    else
                    begin
                        capture_sample_o[u][capture_ready_clear_i[u] ? 3'h0 : wr_r[2:0]] <=
                            '{rising: edge_pol, phase: phase_r, stamp: time_r};
                        wr_r <= capture_ready_clear_i[u] ? 4'h1 : wr_r + 4'h1;
                    end
                    capture_ready_reg_o[u] <= 1'b1;
                end
            end
        end
        assign capture_edge_count_o[u] = cnt_r;
    end

    assign capture_irq_status_reg_o = capture_ready_reg_o & capture_irq_enable_reg_i;

    // Main interrupt status and shared pin
    always_comb
    begin
        main_irq_status_reg_o = 16'h0;
        main_irq_status_reg_o[MAIN_TRIG_BIT] = |(trigger_irq_status_reg_o & trigger_irq_enable_reg_i);
        main_irq_status_reg_o[MAIN_CAP_BIT]  = |capture_irq_status_reg_o;
    end
    assign shared_irq_pin_n_o = ~|(main_irq_status_reg_o & main_irq_enable_reg_i);
endmodule

// ### logic/ptp_evt_pkg.sv
// Package for the time-triggered output and timestamp capture block
// How it works
// - Twelve trigger units, four-bit pin select
// - Shared pin takes OR of units
// - Chained units drive pin one after another
// - Toggle, pulse, periodic and shift outputs
// - Output starts when time equals target
// - Compare runs every time update
// - A unit can make one-hertz pulse
// - Outputs up to 12.5 MHz
// - Done and error bits raise trigger interrupts
// - Input timestamps resolve to 8 ns; the code's phase counts 10 ns clocks
// - Two-bit field selects edge or pulse
// - Capture seconds, nanoseconds and phase
// - Time steps at 25 MHz, phase 125 MHz; the code's phase runs at the 100 MHz clock
// - Nanoseconds-high bit 14 records edge polarity; the code keeps it in the sample's rising field instead
// - Twelve capture units, four-bit pin select
// - Twelve-bit enable gates each capture unit
// - Unit twelve keeps eight, others two
// - Detection sets ready bit and interrupt
// - Status reports edge count and overflow
// - Capture units chain onto one pin; the code has no chaining, each unit captures its pin on its own
// - Inputs detected up to 25 MHz
// - Trigger to bit 10, capture bit 12
package ptp_evt_pkg;
    localparam int NUM_UNITS      = 12;
    localparam int NUM_PINS       = 7;
    localparam int PIN_SEL_LSB    = 0;
    localparam int PIN_SEL_W      = 4;
    localparam int MODE_LSB       = 4;
    localparam int MODE_W         = 3;
    localparam int CAP_DET_LSB    = 6;
    localparam int CAP_PIN_LSB    = 8;
    localparam int NS_HI_EDGE_BIT = 14;
    localparam int MAIN_TRIG_BIT  = 10;
    localparam int MAIN_CAP_BIT   = 12;
    localparam int DEPTH_SMALL    = 2;
    localparam int DEPTH_LAST     = 8;
    localparam int CLK_HZ         = 100_000_000;
    localparam int TICK_HZ        = 25_000_000;
    localparam int TICK_DIV       = CLK_HZ / TICK_HZ;
    localparam int SUB_NS         = 8;
    localparam int TICK_NS        = 1_000_000_000 / TICK_HZ;
    localparam int NS_PER_SEC     = 1_000_000_000;
    localparam logic [2:0] TRIG_NEG_EDGE  = 3'h0;
    localparam logic [2:0] TRIG_POS_EDGE  = 3'h1;
    localparam logic [2:0] TRIG_NEG_PULSE = 3'h2;
    localparam logic [2:0] TRIG_POS_PULSE = 3'h3;
    localparam logic [2:0] TRIG_NEG_PER   = 3'h4;
    localparam logic [2:0] TRIG_POS_PER   = 3'h5;
    localparam logic [2:0] TRIG_SHIFT     = 3'h6;
    localparam logic [1:0] DET_RISE       = 2'h0;
    localparam logic [1:0] DET_FALL       = 2'h1;
    localparam logic [1:0] DET_POS_PULSE  = 2'h2;
    localparam logic [1:0] DET_NEG_PULSE  = 2'h3;

    typedef struct packed {
        logic [31:0] sec;
        logic [29:0] ns;
    } ptp_time_type;

    typedef struct packed {
        logic [15:0] config_first;
        logic [15:0] pulse_width;
        logic [31:0] cycle_width;
        logic [15:0] cycle_count;
        logic [15:0] pattern;
        logic [3:0]  chain_next;
        logic        chain_en;
        ptp_time_type target;
    } trig_cfg_type;

    typedef struct packed {
        logic        rising;
        logic [2:0]  phase;
        ptp_time_type stamp;
    } cap_sample_type;
endpackage

// ### logic/trig_unit.sv
// One trigger output unit: waveform generator started at a target time
`timescale 1ns/1ps
module trig_unit
    import ptp_evt_pkg::*;
(
    input  wire logic         clk_sys_i,
    input  wire logic         rstn_i,
    input  wire logic         ce_i,
    input  wire logic         tick_i,
    input  wire ptp_time_type now_i,
    input  wire trig_cfg_type cfg_i,
    input  wire logic         enable_i,
    input  wire logic         chain_start_i,
    output logic              out_o,
    output logic              active_o,
    output logic              done_o,
    output logic              error_o
);
    logic [2:0]  mode;
    logic [31:0] cnt_r;
    logic [15:0] cyc_r;
    logic [15:0] shreg_r;
    logic [3:0]  bit_r;
    logic        armed_r;
    logic        spent_r;
    logic        hit;
    logic        late;

    assign mode = cfg_i.config_first[MODE_LSB +: MODE_W];
    assign hit  = tick_i && (now_i == cfg_i.target);
    assign late = ({now_i.sec, now_i.ns} > {cfg_i.target.sec, cfg_i.target.ns});

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            armed_r  <= 1'b0;
            active_o <= 1'b0;
            out_o    <= 1'b0;
            done_o   <= 1'b0;
            error_o  <= 1'b0;
            cnt_r    <= 32'h0;
            cyc_r    <= 16'h0;
            shreg_r  <= 16'h0;
            bit_r    <= 4'h0;
            spent_r  <= 1'b0;
        end
        else if (ce_i)
        begin
            done_o  <= 1'b0;
            error_o <= 1'b0;
            if (!enable_i)
            begin
                armed_r  <= 1'b0;
                spent_r  <= 1'b0;
                active_o <= 1'b0;
                out_o    <= 1'b0;
            end
            else if (!armed_r && !active_o && !spent_r)
            begin
                armed_r <= 1'b1;
                error_o <= late && !cfg_i.chain_en;
                out_o   <= mode[0] ? 1'b0 : 1'b1;
            end
            else if (armed_r && (hit || chain_start_i))
            begin
                armed_r  <= 1'b0;
                spent_r  <= 1'b1;
                active_o <= 1'b1;
                cnt_r    <= 32'h0;
                cyc_r    <= 16'h0;
                shreg_r  <= cfg_i.pattern;
                bit_r    <= 4'h0;
                out_o    <= (mode == TRIG_SHIFT) ? cfg_i.pattern[0] : mode[0];
                if (mode == TRIG_NEG_EDGE || mode == TRIG_POS_EDGE)
                begin
                    active_o <= 1'b0;
                    done_o   <= 1'b1;
                end
            end
            else if (active_o)
            begin
                cnt_r <= cnt_r + 32'h1;
                unique case (mode)
                    TRIG_NEG_PULSE, TRIG_POS_PULSE:
                    begin
                        // Width counts 10 ns clock cycles, compared directly with pulse_width
                        if (cnt_r + 32'h1 >= {16'h0, cfg_i.pulse_width})
                        begin
                            out_o    <= ~mode[0];
                            active_o <= 1'b0;
                            done_o   <= 1'b1;
                        end
                    end
                    TRIG_NEG_PER, TRIG_POS_PER:
                    begin
                        if (cnt_r + 32'h1 == {16'h0, cfg_i.pulse_width})
                            out_o <= ~mode[0];
                        if (cnt_r + 32'h1 >= cfg_i.cycle_width)
                        begin
                            cnt_r <= 32'h0;
                            cyc_r <= cyc_r + 16'h1;
                            if (cfg_i.cycle_count != 16'h0 && cyc_r + 16'h1 == cfg_i.cycle_count)
                            begin
                                active_o <= 1'b0;
                                done_o   <= 1'b1;
                            end
                            else
                                out_o <= mode[0];
                        end
                    end
                    TRIG_SHIFT:
                    begin
                        if (cnt_r + 32'h1 >= {16'h0, cfg_i.pulse_width})
                        begin
                            cnt_r   <= 32'h0;
                            bit_r   <= bit_r + 4'h1;
                            shreg_r <= {1'b0, shreg_r[15:1]};
                            out_o   <= shreg_r[1];
                            if (bit_r == 4'hf)
                            begin
                                active_o <= 1'b0;
                                done_o   <= 1'b1;
                                out_o    <= 1'b0;
                            end
                        end
                    end
                    default:
                    begin
                        active_o <= 1'b0;
                        error_o  <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule

// ### test/ptp_evt_checker.sv
// Concurrent checks on the trigger and timestamp block ports
`timescale 1ns/1ps
module ptp_evt_checker
    import ptp_evt_pkg::*;
#(
    parameter int UNITS = NUM_UNITS
)
(
    input wire logic               clk_sys_i,
    input wire logic               rstn_i,
    input wire logic               time_load_i,
    input wire ptp_time_type       sys_time_o,
    input wire logic [2*UNITS-1:0] trigger_irq_enable_reg_i,
    input wire logic [2*UNITS-1:0] trigger_irq_clear_i,
    input wire logic [2*UNITS-1:0] trigger_irq_status_reg_o,
    input wire logic [UNITS-1:0]   capture_unit_enable_reg_i,
    input wire logic [UNITS-1:0]   capture_ready_clear_i,
    input wire logic [UNITS-1:0]   capture_ready_reg_o,
    input wire logic [UNITS-1:0]   capture_irq_enable_reg_i,
    input wire logic [UNITS-1:0]   capture_irq_status_reg_o,
    input wire logic [15:0]        main_irq_enable_reg_i,
    input wire logic [15:0]        main_irq_status_reg_o,
    input wire logic               shared_irq_pin_n_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);

    a_main_trig_or: assert property (main_irq_status_reg_o[10] ==
        |(trigger_irq_status_reg_o & trigger_irq_enable_reg_i)) else $error("trigger summary bit wrong");
    a_main_cap_or: assert property (main_irq_status_reg_o[12] ==
        |capture_irq_status_reg_o) else $error("capture summary bit wrong");
    a_main_rest_zero: assert property ((main_irq_status_reg_o & ~16'h1400) == 16'h0)
        else $error("unused main status bit set");
    a_irq_pin_share: assert property (shared_irq_pin_n_o ==
        !(|(main_irq_status_reg_o & main_irq_enable_reg_i))) else $error("shared irq pin wrong");
    a_cap_irq_mask: assert property (capture_irq_status_reg_o ==
        (capture_ready_reg_o & capture_irq_enable_reg_i)) else $error("capture irq mask wrong");
    a_time_step: assert property ($changed(sys_time_o) && !$past(time_load_i) &&
        !$past(time_load_i, 2) && sys_time_o.sec == $past(sys_time_o.sec)
        |-> sys_time_o.ns == $past(sys_time_o.ns) + 30'h28) else $error("time step not 40 ns");
    a_ready_sticky: assert property ((~capture_ready_reg_o & $past(capture_ready_reg_o)
        & ~$past(capture_ready_clear_i)) == '0) else $error("ready dropped without clear");
    a_trig_sticky: assert property ((~trigger_irq_status_reg_o & $past(trigger_irq_status_reg_o)
        & ~$past(trigger_irq_clear_i)) == '0) else $error("trigger status dropped without clear");
    a_ready_needs_en: assert property ((capture_ready_reg_o & ~$past(capture_ready_reg_o)
        & ~$past(capture_unit_enable_reg_i)) == '0) else $error("disabled unit became ready");

    c_cap_ready: cover property (|capture_ready_reg_o);
    c_trig_done: cover property (|trigger_irq_status_reg_o[UNITS-1:0]);
    c_irq_low: cover property (!shared_irq_pin_n_o);
endmodule

// ### test/gpio_far_model.sv
// Far-side pin model: resolves pin levels and makes input events
`timescale 1ns/1ps
module gpio_far_model
    import ptp_evt_pkg::*;
(
    input  wire logic [NUM_PINS-1:0] drv_val_i,
    input  wire logic [NUM_PINS-1:0] drv_oe_n_i,
    output logic [NUM_PINS-1:0]      pin_level_o
);
    logic [NUM_PINS-1:0] ext_r = '0;
    // Driven pins show the block's value, others the far side level
    assign pin_level_o = (~drv_oe_n_i & drv_val_i) | (drv_oe_n_i & ext_r);
    task automatic set_level(input int pin, input logic lvl);
        ext_r[pin] = lvl;
    endtask
    // Pulse width in ns, kept well inside the 25 MHz event rate
    task automatic pulse(input int pin, input logic act, input int width);
        ext_r[pin] = act;
        #(width);
        ext_r[pin] = ~act;
    endtask
endmodule

// ### test/ptp_evt_top_bench.sv
// Self-checking bench for the trigger and timestamp block
`timescale 1ns/1ps
module ptp_evt_top_bench;
    import ptp_evt_pkg::*;
    typedef struct packed {
        logic [1:0] det;
        logic       idle;
        logic       act;
        logic [3:0] cnt;
        logic       rise0;
    } row_type;
    logic                                           clk_sys_i, rstn_i, time_load_i, irq_n;
    ptp_time_type                                   load_val, now;
    trig_cfg_type [NUM_UNITS-1:0]                   tcfg;
    logic [NUM_UNITS-1:0]                           ten, cen, rclr, rdy, cie, cis, tact, ovf;
    logic [2*NUM_UNITS-1:0]                         tie, tclr, tis;
    logic [NUM_UNITS-1:0][15:0]                     ccfg;
    cap_sample_type [NUM_UNITS-1:0][DEPTH_LAST-1:0] smp;
    logic [NUM_UNITS-1:0][3:0]                      cnt;
    logic [15:0]                                    mie, mis;
    logic [NUM_PINS-1:0]                            pin, gout, goe_n;
    int                                             miscompares, total_checks, k, hi;
    row_type                                        rows [4] = '{
        '{DET_RISE, 1'b0, 1'b1, 4'h1, 1'b1}, '{DET_FALL, 1'b0, 1'b1, 4'h1, 1'b0},
        '{DET_POS_PULSE, 1'b0, 1'b1, 4'h2, 1'b1}, '{DET_NEG_PULSE, 1'b1, 1'b0, 4'h2, 1'b0}};

    ptp_evt_top u_ptp_evt_top (.clk_sys_i, .rstn_i, .ce_i(1'b1), .time_load_i, .time_load_val_i(load_val),
        .sys_time_o(now), .trig_cfg_i(tcfg), .trigger_unit_enable_reg_i(ten), .trigger_irq_enable_reg_i(tie),
        .trigger_irq_clear_i(tclr), .trigger_irq_status_reg_o(tis), .trigger_active_o(tact),
        .capture_unit_config_i(ccfg), .capture_unit_enable_reg_i(cen), .capture_ready_clear_i(rclr),
        .capture_ready_reg_o(rdy), .capture_irq_enable_reg_i(cie), .capture_irq_status_reg_o(cis),
        .capture_sample_o(smp), .capture_edge_count_o(cnt), .capture_overflow_o(ovf),
        .main_irq_enable_reg_i(mie), .main_irq_status_reg_o(mis), .shared_irq_pin_n_o(irq_n),
        .gpio_in_i(pin), .gpio_out_o(gout), .gpio_oe_n_o(goe_n));
    gpio_far_model u_gpio_far_model (.drv_val_i(gout), .drv_oe_n_i(goe_n), .pin_level_o(pin));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic time_out();
        miscompares++;
        $display("wrong value at %0t: wait ran out", $time);
        wrap_up();
    endtask

    initial
    begin
        {rstn_i, time_load_i, load_val, tcfg, ten, tie, tclr, ccfg, cen, rclr, cie, mie} = '0;
        miscompares = 0;
        total_checks = 0;
        repeat (5) @(posedge clk_sys_i);
        #1 rstn_i = 1'b1;
        check(goe_n, 7'h7f);
        check(irq_n, 1'b1);
        check(rdy, 12'h000);
        time_load_i = 1'b1;
        load_val = '{sec: 32'h5, ns: 30'h0};
        cyc(1);
        time_load_i = 1'b0;
        tcfg[0].config_first = {9'h0, TRIG_POS_EDGE, 4'h2};
        tcfg[0].target = '{sec: 32'h5, ns: 30'h320};
        tcfg[1].config_first = {9'h0, TRIG_POS_EDGE, 4'h7};
        tcfg[1].target = '{sec: 32'h5, ns: 30'h0};
        tcfg[2].config_first = {9'h0, TRIG_POS_PULSE, 4'h4};
        tcfg[2].pulse_width = 16'h0008;
        tcfg[2].target = '{sec: 32'h5, ns: 30'h668};
        tcfg[3].config_first = {9'h0, TRIG_POS_PULSE, 4'h4};
        tcfg[3].pulse_width = 16'h0004;
        tcfg[3].target = '{sec: 32'h5, ns: 30'h640};
        cyc(8);
        ten[3:0] = 4'hf;
        for (k = 0; k < 300 && gout[2] !== 1'b1; k++)
            cyc(1);
        if (k == 300)
            time_out();
        check(now.ns, 30'h320 + 30'(TICK_NS));
        check(goe_n[2], 1'b0);
        for (k = 0; k < 300 && gout[4] !== 1'b1; k++)
            cyc(1);
        if (k == 300)
            time_out();
        check(tact, 12'h008);
        for (hi = 0; hi < 40 && gout[4] === 1'b1; hi++)
            cyc(1);
        check(hi, 12);
        check(tis[0], 1'b1);
        check(tis[13], 1'b1);
        tie[0] = 1'b1;
        mie[10] = 1'b1;
        cyc(1);
        check(irq_n, 1'b0);
        ten = '0;
        tclr = '1;
        cyc(1);
        tclr = '0;
        cyc(1);
        check(tis, 24'h0);
        tcfg[4].config_first = {9'h0, TRIG_POS_PER, 4'h3};
        tcfg[4].pulse_width = 16'h0002;
        tcfg[4].cycle_width = 32'h4;
        tcfg[4].cycle_count = 16'h0002;
        tcfg[4].chain_next = 4'h5;
        tcfg[4].chain_en = 1'b1;
        tcfg[4].target = '{sec: 32'h5, ns: 30'hfa0};
        tcfg[5].config_first = {9'h0, TRIG_POS_EDGE, 4'h3};
        tcfg[5].target = '{sec: 32'h6, ns: 30'h0};
        ten[5:4] = 2'h3;
        for (k = 0; k < 300 && gout[3] !== 1'b1; k++)
            cyc(1);
        if (k == 300)
            time_out();
        hi = 0;
        for (k = 0; k < 10; k++)
        begin
            hi = hi * 2 + gout[3];
            cyc(1);
        end
        check(hi, 10'h331);
        check(tis[5:4], 2'h3);
        ten = '0;
        foreach (rows[r])
        begin
            u_gpio_far_model.set_level(1, rows[r].idle);
            ccfg[0] = {4'h0, 4'h1, rows[r].det, 6'h00};
            cyc(8);
            cen[0] = 1'b1;
            u_gpio_far_model.pulse(1, rows[r].act, 80);
            cyc(8);
            check(rdy[0], 1'b1);
            check(cnt[0], rows[r].cnt);
            check(smp[0][0].rising, rows[r].rise0);
            check(smp[0][0].stamp.sec, 32'h5);
            cen[0] = 1'b0;
            rclr[0] = 1'b1;
            cyc(1);
            rclr[0] = 1'b0;
            cyc(1);
            check(rdy[0], 1'b0);
        end
        u_gpio_far_model.set_level(5, 1'b0);
        ccfg[11] = {4'h0, 4'h5, DET_POS_PULSE, 6'h00};
        ccfg[0] = {4'h0, 4'h5, DET_RISE, 6'h00};
        cen = 12'h801;
        cie[11] = 1'b1;
        mie[12] = 1'b1;
        cyc(8);
        repeat (4)
        begin
            u_gpio_far_model.pulse(5, 1'b1, 80);
            cyc(8);
        end
        check(ovf[11], 1'b0);
        check(cnt[11], 4'h8);
        check(smp[11][7].rising, 1'b0);
        check(ovf[0], 1'b1);
        check(irq_n, 1'b0);
        u_gpio_far_model.pulse(5, 1'b1, 80);
        cyc(8);
        check(ovf[11], 1'b1);
        cen = '0;
        rstn_i = 1'b0;
        cyc(3);
        rstn_i = 1'b1;
        check(rdy, 12'h000);
        check(goe_n, 7'h7f);
        wrap_up();
    end
endmodule

bind ptp_evt_top ptp_evt_checker #(.UNITS(UNITS)) u_ptp_evt_checker (.clk_sys_i, .rstn_i, .time_load_i,
    .sys_time_o, .trigger_irq_enable_reg_i, .trigger_irq_clear_i, .trigger_irq_status_reg_o,
    .capture_unit_enable_reg_i, .capture_ready_clear_i, .capture_ready_reg_o, .capture_irq_enable_reg_i,
    .capture_irq_status_reg_o, .main_irq_enable_reg_i, .main_irq_status_reg_o, .shared_irq_pin_n_o);
